// ---- hdl/stc_cutoff.sv ----
// Torque-cutoff supervision: gates the power stage, picks the indication,
// reports path states, and offers status and interrupts over AXI4-Lite.
// Assumes cutoff and enable pins are asynchronous 24 V levels made logic.
// Operation
// - Single path: power stage released only while cutoff input is high.
// - Dual path: released only while both paths are high.
// - Single path indication: warning, fault, mode, or mode with dot.
// - Dual path: any low path cuts torque; safe only when both low.
// - Cutoff during operation lets motor coast and raises the fault code.
// - Low test pulses up to 300 us, 200 ms apart, are ignored.
// - Longer or more frequent pulses count as a real cutoff.
// - Dual path torque-off completes in under 10 ms.
// - With auto-enable set, the drive enables itself after power-up.
// - Each path state output shows its own pulse inhibitor state.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module stc_cutoff #(
  parameter int unsigned PULSE_MAX = stc_pkg::PULSE_MAX_CYC,
  parameter int unsigned PULSE_GAP = stc_pkg::PULSE_GAP_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Cutoff and enable pins
  input wire logic TORQUE_CUTOFF_INPUT,
  input wire logic CUTOFF_PATH_B,
  input wire logic HW_ENABLE,
  // Power stage and indication
  output logic POWER_STAGE_EN,
  output logic SAFE_STATE,
  output logic [1:0] INDICATION,
  output logic PATH_STATE_A,
  output logic PATH_STATE_B,
  output logic IRQ,
  // AXI4-Lite write address
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  logic path_a;
  logic path_b;
  logic raw_a;
  logic raw_b;
  logic en_s1_reg;
  logic en_s2_reg;
  logic [2:0] ctrl_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic sampled_reg;
  logic cutoff_ok;
  logic drive_en;
  logic prev_torque_reg;
  logic prev_fault_reg;
  stc_pkg::stc_status_t st_next;
  stc_pkg::stc_status_t st_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic [31:0] rd_word;

  // ****************************************
  // Input paths
  // ****************************************
  stc_path_filter #(
    .PULSE_MAX(PULSE_MAX),
    .PULSE_GAP(PULSE_GAP)
  ) u_path_a (
    .clk(CLK),
    .reset_n(RESET_N),
    .pin(TORQUE_CUTOFF_INPUT),
    .level(path_a),
    .raw(raw_a)
  );

  stc_path_filter #(
    .PULSE_MAX(PULSE_MAX),
    .PULSE_GAP(PULSE_GAP)
  ) u_path_b (
    .clk(CLK),
    .reset_n(RESET_N),
    .pin(CUTOFF_PATH_B),
    .level(path_b),
    .raw(raw_b)
  );

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
    end else begin
      en_s1_reg <= HW_ENABLE;
      en_s2_reg <= en_s1_reg;
    end
  end

  // Torque is held off for the first clock after reset only; the flag sets whatever the synchronisers hold
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sampled_reg <= 1'b0;
    end else if (raw_a || raw_b || en_s2_reg || !sampled_reg) begin
      sampled_reg <= 1'b1;
    end
  end

  // ****************************************
  // Decision and indication
  // ****************************************
  // Auto-enable stands in for the software enable after power-up.
  assign drive_en = en_s2_reg &&
    (ctrl_reg[stc_pkg::CTRL_AUTOEN_BIT] ||
     ctrl_reg[stc_pkg::CTRL_SWEN_BIT]);

  assign cutoff_ok = ctrl_reg[stc_pkg::CTRL_DUAL_BIT] ?
    (path_a && path_b) : path_a;

  always_comb begin
    st_next.torque_on = sampled_reg && cutoff_ok && drive_en;
    st_next.safe = ctrl_reg[stc_pkg::CTRL_DUAL_BIT] ?
      (!path_a && !path_b) : !path_a;
    if (!cutoff_ok) begin
      st_next.ind = drive_en ? stc_pkg::STC_IND_FAULT :
        stc_pkg::STC_IND_WARN;
    end else begin
      st_next.ind = drive_en ? stc_pkg::STC_IND_MODE_DOT :
        stc_pkg::STC_IND_MODE;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_reg <= '{torque_on: 1'b0, safe: 1'b1,
                  ind: stc_pkg::STC_IND_WARN};
    end else begin
      st_reg <= st_next;
    end
  end

  assign POWER_STAGE_EN = st_reg.torque_on;
  assign SAFE_STATE = st_reg.safe;
  assign INDICATION = st_reg.ind;
  // Inhibitor state per path, one clock after the filtered level
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PATH_STATE_A <= 1'b0;
      PATH_STATE_B <= 1'b0;
    end else begin
      PATH_STATE_A <= path_a;
      PATH_STATE_B <= path_b;
    end
  end

  // ****************************************
  // Events and interrupt
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      prev_torque_reg <= 1'b0;
      prev_fault_reg <= 1'b0;
    end else begin
      prev_torque_reg <= st_reg.torque_on;
      prev_fault_reg <= (st_reg.ind == stc_pkg::STC_IND_FAULT);
    end
  end

  always_comb begin
    irq_set = 3'h0;
    irq_set[stc_pkg::IRQ_CUTOFF_BIT] = prev_torque_reg && !st_reg.torque_on;
    irq_set[stc_pkg::IRQ_FAULT_BIT] = !prev_fault_reg &&
      (st_reg.ind == stc_pkg::STC_IND_FAULT);
    irq_set[stc_pkg::IRQ_MISMATCH_BIT] =
      ctrl_reg[stc_pkg::CTRL_DUAL_BIT] && (path_a != path_b);
    irq_clr = 3'h0;
    if (wr_fire && awaddr_reg == stc_pkg::OFS_IRQ_STAT && wstrb_reg[0]) begin
      irq_clr = wdata_reg[2:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign AWREADY = !aw_held_reg && !BVALID;
  assign WREADY = !w_held_reg && !BVALID;
  assign wr_fire = aw_held_reg && w_held_reg && !BVALID;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= stc_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (awaddr_reg == stc_pkg::OFS_CTRL ||
                  awaddr_reg == stc_pkg::OFS_IRQ_STAT ||
                  awaddr_reg == stc_pkg::OFS_IRQ_MASK) ?
          stc_pkg::RESP_OKAY : stc_pkg::RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_reg <= stc_pkg::CTRL_RESET;
      irq_mask_reg <= stc_pkg::IRQ_MASK_RESET;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == stc_pkg::OFS_CTRL) begin
        ctrl_reg <= wdata_reg[2:0];
      end
      if (awaddr_reg == stc_pkg::OFS_IRQ_MASK) begin
        irq_mask_reg <= wdata_reg[2:0];
      end
    end
  end

  always_comb begin
    rd_word = 32'h0;
    case (ARADDR)
      stc_pkg::OFS_CTRL: rd_word = {29'h0, ctrl_reg};
      stc_pkg::OFS_STAT: rd_word = {24'h0, raw_b, raw_a, PATH_STATE_B,
        PATH_STATE_A, st_reg.ind, st_reg.safe, st_reg.torque_on};
      stc_pkg::OFS_IRQ_STAT: rd_word = {29'h0, irq_stat_reg};
      stc_pkg::OFS_IRQ_MASK: rd_word = {29'h0, irq_mask_reg};
      default: rd_word = 32'h0;
    endcase
  end

  assign ARREADY = !RVALID;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= stc_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= (ARADDR == stc_pkg::OFS_CTRL || ARADDR == stc_pkg::OFS_STAT ||
                ARADDR == stc_pkg::OFS_IRQ_STAT ||
                ARADDR == stc_pkg::OFS_IRQ_MASK) ?
        stc_pkg::RESP_OKAY : stc_pkg::RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

endmodule : stc_cutoff
`default_nettype wire

// ---- hdl/stc_pkg.sv ----
// Package for the torque-cutoff supervision block: timing, codes, carriers.
// Assumes a 250 MHz logic clock; the cutoff and enable pins arrive asynchronously.
package stc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned PULSE_MAX_US = 300;
  localparam int unsigned PULSE_GAP_MS = 200;
  localparam int unsigned REACT_MS = 10;
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PULSE_GAP_CYC = PULSE_GAP_MS * (CLK_HZ / 1_000);
  localparam int unsigned REACT_CYC = REACT_MS * (CLK_HZ / 1_000);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_AUTOEN_BIT = 1;
  localparam int CTRL_SWEN_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int IRQ_CUTOFF_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_MISMATCH_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Indication
  // ****************************************
  typedef enum logic [1:0] {
    STC_IND_WARN,
    STC_IND_FAULT,
    STC_IND_MODE,
    STC_IND_MODE_DOT
  } stc_ind_t;

  typedef struct packed {
    logic torque_on;
    logic safe;
    stc_ind_t ind;
  } stc_status_t;

endpackage : stc_pkg

// ---- hdl/stc_path_filter.sv ----
// One cutoff path: two-stage synchroniser and test pulse filter.
// Assumes an asynchronous level input and the block's single clock.
`timescale 1ns/1ps
`default_nettype none
module stc_path_filter #(
  parameter int unsigned PULSE_MAX = stc_pkg::PULSE_MAX_CYC,
  parameter int unsigned PULSE_GAP = stc_pkg::PULSE_GAP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw pin and filtered state
  input wire logic pin,
  output logic level,
  output logic raw
);

  logic sync1_reg;
  logic sync2_reg;
  logic level_reg;
  logic [31:0] low_cnt_reg;
  logic [31:0] gap_cnt_reg;
  logic pulse_seen_reg;

  // ****************************************
  // Synchroniser
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************
  // Pulse filter
  // ****************************************
  // Short low pulses are bridged only when spaced apart; a long or too
  // frequent low drops the level.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_reg <= 1'b0;
      low_cnt_reg <= 32'h0;
      gap_cnt_reg <= 32'h0;
      pulse_seen_reg <= 1'b0;
    end else if (sync2_reg) begin
      low_cnt_reg <= 32'h0;
      // Only a bridged short low counts as a test pulse; the reset fill
      // of the synchroniser and a real cutoff do not start a gap window.
      if (low_cnt_reg != 32'h0) begin
        gap_cnt_reg <= 32'h0;
        pulse_seen_reg <= level_reg;
      end else if (gap_cnt_reg < PULSE_GAP) begin
        gap_cnt_reg <= gap_cnt_reg + 32'h1;
      end
      if (low_cnt_reg == 32'h0 || level_reg == 1'b0) begin
        level_reg <= (low_cnt_reg == 32'h0) ? 1'b1 : level_reg;
      end
    end else begin
      if (low_cnt_reg < PULSE_MAX + 1) begin
        low_cnt_reg <= low_cnt_reg + 32'h1;
      end
      if (low_cnt_reg >= PULSE_MAX) begin
        level_reg <= 1'b0;
      end else if (low_cnt_reg == 32'h0 && pulse_seen_reg &&
                   gap_cnt_reg < PULSE_GAP) begin
        level_reg <= 1'b0;
      end else if (!level_reg) begin
        level_reg <= 1'b0;
      end
    end
  end

  assign level = level_reg;
  assign raw = sync2_reg;

endmodule : stc_path_filter
`default_nettype wire

// ---- verif/stc_relay_model.sv ----
// Safety relay model driving the two cutoff paths of the block.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module stc_relay_model (
  // Clock
  input wire logic clk,
  // Cutoff outputs
  output logic path_a,
  output logic path_b
);
  // Start of simulation: both paths held high
  initial begin
    path_a = 1'h1;
    path_b = 1'h1;
  end
  // Two separate outputs, each switched on its own
  task automatic set(input logic a, input logic b);
    path_a <= a;
    path_b <= b;
  endtask : set
  // Low-going self-test pulse on path a
  task automatic pulse(input int w);
    path_a <= 1'h0;
    repeat (w) @(posedge clk);
    path_a <= 1'h1;
  endtask : pulse
endmodule : stc_relay_model
`default_nettype wire

// ---- verif/stc_cutoff_asserts.sv ----
// Checker for the torque-cutoff block, watching its top ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module stc_cutoff_asserts #(
  parameter int unsigned PULSE_MAX = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Pins
  input wire logic TORQUE_CUTOFF_INPUT,
  input wire logic CUTOFF_PATH_B,
  input wire logic POWER_STAGE_EN,
  input wire logic SAFE_STATE,
  input wire logic [1:0] INDICATION,
  input wire logic PATH_STATE_A,
  input wire logic PATH_STATE_B,
  // Bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  int unsigned lo_a;
  int unsigned hi_a;
  int unsigned hi_b;
  // Run lengths of pin levels
  always_ff @(posedge CLK) begin
    lo_a <= (!RESET_N || TORQUE_CUTOFF_INPUT) ? 0 : lo_a + 1;
    hi_a <= (!RESET_N || !TORQUE_CUTOFF_INPUT) ? 0 : hi_a + 1;
    hi_b <= (!RESET_N || !CUTOFF_PATH_B) ? 0 : hi_b + 1;
  end
  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_rd_taken;
    ARVALID && ARREADY;
  endsequence
  a_reset_outputs: assert property (disable iff (1'h0)
    !RESET_N |=> !POWER_STAGE_EN && SAFE_STATE && INDICATION == 2'h0)
    else $error("outputs not idle after reset");
  a_long_low_cuts: assert property (lo_a > PULSE_MAX + 8 |->
    !PATH_STATE_A && !POWER_STAGE_EN) else $error("long low kept torque");
  a_path_a_follows: assert property (hi_a > 8 |-> PATH_STATE_A)
    else $error("path state a not high");
  a_path_b_follows: assert property (hi_b > 8 |-> PATH_STATE_B)
    else $error("path state b not high");
  a_torque_dot: assert property (POWER_STAGE_EN |->
    INDICATION == 2'h3 && !SAFE_STATE) else $error("torque without dot");
  // Both channels are latched first, the response rises one edge later
  a_write_answer: assert property (s_wr_taken |-> ##2 BVALID)
    else $error("no write response");
  a_read_answer: assert property (s_rd_taken |=> RVALID)
    else $error("no read data");
  a_b_one_beat: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response repeated");
  a_r_one_beat: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read data repeated");
  a_busy_refuse: assert property (BVALID |-> !AWREADY)
    else $error("address taken during response");
endmodule : stc_cutoff_asserts
`default_nettype wire

// ---- verif/stc_cutoff_tb_top.sv ----
// Bench for the torque-cutoff block: bus tasks and pin scenarios.
// Assumes the relay model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module stc_cutoff_tb_top;
  localparam int PM = 20;
  localparam int PG = 200;
  logic clk, reset_n = 1'h0, hw_en = 1'h0, pa, pb;
  logic pse, safe, psa, psb, irq, awr, wr, bv, arr, rv;
  logic [1:0] ind, bresp, rresp;
  logic [31:0] rdata, wdata = 32'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic [1:0] seq1 [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
  logic pse_q = 1'h0;
  int n_mismatch = 0, check_count = 0, drops = 0;
  stc_relay_model relay (.clk(clk), .path_a(pa), .path_b(pb));
  stc_cutoff #(.PULSE_MAX(PM), .PULSE_GAP(PG)) DUT (.CLK(clk),
    .RESET_N(reset_n), .TORQUE_CUTOFF_INPUT(pa), .CUTOFF_PATH_B(pb),
    .HW_ENABLE(hw_en), .POWER_STAGE_EN(pse), .SAFE_STATE(safe),
    .INDICATION(ind), .PATH_STATE_A(psa), .PATH_STATE_B(psb), .IRQ(irq),
    .AWADDR(awaddr), .AWVALID(awv), .AWREADY(awr), .WDATA(wdata),
    .WSTRB(4'hf), .WVALID(wv), .WREADY(wr), .BRESP(bresp), .BVALID(bv),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arv), .ARREADY(arr),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rv), .RREADY(rready));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Counts falls of the power stage enable
  always @(posedge clk) begin
    pse_q <= pse;
    if (pse_q && !pse) drops++;
  end
  task automatic complete_run();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 200) begin
      n_mismatch++;
      complete_run();
    end
  endtask : tick
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do begin
      tick(n);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end while (!bv);
    chk(32'(bresp), 32'(er));
    bready <= 1'h0;
  endtask : wchk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    do begin
      tick(n);
      if (arr) arv <= 1'h0;
    end while (!rv);
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    rready <= 1'h0;
  endtask : rchk
  task automatic settle();
    repeat (PM + 12) @(posedge clk);
  endtask : settle
  task automatic irqchk(input logic e);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'(e));
  endtask : irqchk
  initial begin
    logic [1:0] c;
    logic [2:0] c3;
    int n, d0;
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    rchk(stc_pkg::OFS_CTRL, 32'h0, stc_pkg::RESP_OKAY);
    rchk(stc_pkg::OFS_IRQ_MASK, 32'h0, stc_pkg::RESP_OKAY);
    rchk(8'h10, 32'h0, stc_pkg::RESP_SLVERR);
    wchk(8'h10, 32'hffffffff, stc_pkg::RESP_SLVERR);
    wchk(stc_pkg::OFS_CTRL, 32'h2, stc_pkg::RESP_OKAY);
    foreach (seq1[k]) begin
      c = seq1[k];
      relay.set(c[1], 1'h1);
      hw_en <= c[0];
      settle();
      chk(32'({pse, safe, ind, psa}), 32'({&c, !c[1], c, c[1]}));
    end
    rchk(stc_pkg::OFS_IRQ_STAT, 32'h3, stc_pkg::RESP_OKAY);
    irqchk(1'h0);
    wchk(stc_pkg::OFS_IRQ_MASK, 32'h1, stc_pkg::RESP_OKAY);
    irqchk(1'h1);
    wchk(stc_pkg::OFS_IRQ_STAT, 32'h1, stc_pkg::RESP_OKAY);
    irqchk(1'h0);
    rchk(stc_pkg::OFS_IRQ_STAT, 32'h2, stc_pkg::RESP_OKAY);
    relay.set(1'h1, 1'h1);
    hw_en <= 1'h1;
    settle();
    rchk(stc_pkg::OFS_STAT, 32'hfd, stc_pkg::RESP_OKAY);
    d0 = drops;
    relay.pulse(PM - 1);
    repeat (PG + 10) @(posedge clk);
    relay.pulse(PM - 1);
    settle();
    chk(drops - d0, 32'h0);
    relay.pulse(PM - 1);
    settle();
    chk(drops - d0, 32'h1);
    relay.pulse(PM + 8);
    settle();
    chk(drops - d0, 32'h2);
    wchk(stc_pkg::OFS_IRQ_STAT, 32'h7, stc_pkg::RESP_OKAY);
    wchk(stc_pkg::OFS_CTRL, 32'h3, stc_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      c3 = 3'(i);
      relay.set(c3[2], c3[1]);
      hw_en <= c3[0];
      settle();
      chk(32'({pse, safe, ind, psa, psb}), 32'({&c3, !c3[2] && !c3[1],
          c3[2] & c3[1], c3[0], c3[2], c3[1]}));
    end
    rchk(stc_pkg::OFS_IRQ_STAT, 32'h7, stc_pkg::RESP_OKAY);
    relay.set(1'h1, 1'h0);
    n = 0;
    while (pse && n < PM + 8) begin
      @(posedge clk);
      n++;
    end
    chk(32'(pse), 32'h0);
    relay.set(1'h1, 1'h1);
    settle();
    reset_n <= 1'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    settle();
    chk(32'(pse), 32'h0);
    wchk(stc_pkg::OFS_CTRL, 32'h4, stc_pkg::RESP_OKAY);
    settle();
    chk(32'(pse), 32'h1);
    hw_en <= 1'h0;
    repeat (8) @(posedge clk);
    relay.set(1'h0, 1'h0);
    settle();
    chk(32'({safe, ind}), 32'h4);
    complete_run();
  end
endmodule : stc_cutoff_tb_top
bind stc_cutoff stc_cutoff_asserts #(.PULSE_MAX(PULSE_MAX)) u_chk (.CLK,
  .RESET_N, .TORQUE_CUTOFF_INPUT, .CUTOFF_PATH_B, .POWER_STAGE_EN,
  .SAFE_STATE, .INDICATION, .PATH_STATE_A, .PATH_STATE_B, .AWVALID,
  .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .ARVALID, .ARREADY,
  .RVALID, .RREADY);
`default_nettype wire
